// *** reprogram_poll_and_control_msgs_test.sv ***
// Purpose: Self-checking bench for rpc_core.
// Assumes: One enable discrete; second area set only for configuration reads.
// Notes:   Seed 13; loader model stalls at random.
`timescale 1ns/1ns
`include "rpc_map.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module reprogram_poll_and_control_msgs_test;
  logic clk_sys = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, reprog_en1 = 0, reprog_en2 = 0, cmd_vld = 0, rx_vld = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rd, cfg;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [15:0] cmd_word = 0, rx_word = 0, req, n0, n1, n2, k, dw[4];
  logic [15:0] tab[9] = '{16'hc180, 16'hc320, 16'h4220, 16'h8220, 16'hc220, 16'hc008, 16'hc001, 16'hc002, 16'hc140};
  logic [4:0] rt_addr = 0;
  logic [5:0] fill;
  logic [1:0] rs;
  bit ok, a1, a2, ld, vf;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_vld, tx_last, tx_rdy;
  wire area1_active, area2_active, load_follows, verify_follows, exec_entry, revert_to_bc;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] tx_word;
  int error_cnt = 0, n_compared = 0, ex_n = 0, rv_n = 0;
  rpc_core u_dut (.*);
  rpc_loader u_lp (.*);
  initial forever #4 clk_sys = ~clk_sys;
  // Counts one-cycle action pulses.
  always @(posedge clk_sys) begin
    ex_n += exec_entry;
    rv_n += revert_to_bc;
  end
  function automatic [15:0] cw(input [10:0] x);
    return {rt_addr, x};
  endfunction
  function automatic [15:0] act_exp(input [1:0] c, input [15:0] r);
    return {c[0] & c[1], 4'h0, c[0] ? 11'h0 : r[10:0]};
  endfunction
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  // Sends a command and nd data words, then waits for nr reply words.
  task automatic msg(input [15:0] c, input int nd, input int nr);
    u_lp.q.delete();
    @(posedge clk_sys);
    cmd_vld <= 1'b1;
    cmd_word <= c;
    for (int j = 0; j < nd; j++) begin
      @(posedge clk_sys);
      cmd_vld <= 1'b0;
      rx_vld <= 1'b1;
      rx_word <= dw[j];
    end
    @(posedge clk_sys);
    cmd_vld <= 1'b0;
    rx_vld <= 1'b0;
    while (u_lp.q.size() < nr) @(posedge clk_sys);
  endtask
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end
  initial begin
    fill = $urandom(13);
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    rt_addr <= $urandom % 31;
    // Polls under each busy setting, a fresh request each time.
    for (int c = 0; c < 4; c++) begin
      req = {5'h10, 1'($urandom), 5'($urandom % 29), 5'($urandom)};
      wr(`RPC_A_CTRL, c);
      wr(`RPC_A_REQ, req);
      msg(cw(11'h4e1), 0, 2);
      `CHK(u_lp.q[0][15:11], rt_addr)
      `CHK(u_lp.q[0][3], c == 1)
      `CHK(u_lp.q[1][14:11], 4'h0)
      if (c != 1) `CHK(u_lp.q[1], act_exp(c, req))
    end
    cfg = $urandom;
    wr(`RPC_A_CFG, cfg);
    for (int a = 0; a < 2; a++) begin
      wr(`RPC_A_CTRL, a << 3);
      msg(cw(11'h662), 0, 3);
      `CHK(u_lp.q[1], cfg[15:0])
      `CHK(u_lp.q[2], a ? cfg[31:16] : 16'h0)
    end
    wr(`RPC_A_CTRL, 0);
    rdr(8'h40);
    `CHK({rs, rd}, {`RPC_RESP_ERR, 32'h0})
    n0 = $urandom;
    n1 = $urandom;
    n2 = $urandom;
    wr(`RPC_A_NOM0, n0);
    wr(`RPC_A_NOM1, n1);
    wr(`RPC_A_NOM2, n2);
    wr(`RPC_A_FILL, fill);
    // Each entry: enable, good name, load/verify field, code.
    foreach (tab[i]) begin
      k = tab[i];
      ok = k[15] && k[14] && k[9:8] != 2'b11 && k[7:0] inside {0, 1, 2, 8'h10, 8'h20, 8'h30, 8'h40, 8'h80, 8'hc0};
      dw = '{n0, k[14] ? n1 : ~n1, n2, {fill, k[9:0]}};
      @(posedge clk_sys);
      reprog_en1 <= k[15];
      ex_n = 0;
      rv_n = 0;
      msg(cw(11'h3a4), 4, 1);
      repeat (3) @(posedge clk_sys);
      if (ok) begin
        a1 = k[7] | a1 & k[7:0] != 8'h20;
        a2 = k[6] | a2 & k[7:0] != 8'h10;
        ld = k[9:8] == 2'b01;
        vf = k[9:8] == 2'b10;
      end
      `CHK({area1_active, area2_active, load_follows, verify_follows}, {a1, a2, ld, vf})
      `CHK({ex_n[1:0], rv_n[1:0]}, {2'(ok && k[7:0] == 1), 2'(ok && k[7:0] == 2)})
      rdr(`RPC_A_STAT);
      `CHK(rd[5], !ok)
    end
    conclude();
  end
endmodule // reprogram_poll_and_control_msgs_test

// *** rpc_axil.v ***
// Purpose: AXI4-Lite slave handshake for the register file.
// Assumes: One write and one read outstanding at most.
// Notes:   Read data is decoded by the parent from the live address.
`timescale 1ns/1ns
`include "rpc_map.vh"
module rpc_axil (
  // Clock and reset
  input  wire                clk_sys,
  input  wire                srst,
  // Write channels
  input  wire [`RPC_AW-1:0]  s_axi_awaddr,
  input  wire                s_axi_awvalid,
  output wire                s_axi_awready,
  input  wire [31:0]         s_axi_wdata,
  input  wire [3:0]          s_axi_wstrb,
  input  wire                s_axi_wvalid,
  output wire                s_axi_wready,
  output wire [1:0]          s_axi_bresp,
  output wire                s_axi_bvalid,
  input  wire                s_axi_bready,
  // Read channels
  input  wire                s_axi_arvalid,
  output wire                s_axi_arready,
  output wire [31:0]         s_axi_rdata,
  output wire [1:0]          s_axi_rresp,
  output wire                s_axi_rvalid,
  input  wire                s_axi_rready,
  // Register side
  output wire                wr_en,
  output wire [`RPC_AW-1:0]  wr_addr,
  output wire [31:0]         wr_data,
  output wire [3:0]          wr_strb,
  input  wire                wr_hit,
  input  wire [31:0]         rd_data,
  input  wire                rd_hit
);
  reg               aw_full_ff;
  reg               w_full_ff;
  reg [`RPC_AW-1:0] awaddr_ff;
  reg [31:0]        wdata_ff;
  reg [3:0]         wstrb_ff;
  reg               bvalid_ff;
  reg [1:0]         bresp_ff;
  reg               rvalid_ff;
  reg [1:0]         rresp_ff;
  reg [31:0]        rdata_ff;

  assign s_axi_awready = ~aw_full_ff;
  assign s_axi_wready  = ~w_full_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  // The write fires once both halves are held and the last response is gone.
  assign wr_en   = aw_full_ff & w_full_ff & ~bvalid_ff;
  assign wr_addr = awaddr_ff;
  assign wr_data = wdata_ff;
  assign wr_strb = wstrb_ff;

  // Address and data are caught in either order.
  always @(posedge clk_sys) begin
    if (srst) begin
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      awaddr_ff  <= {`RPC_AW{1'b0}};
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `RPC_RESP_OK;
    end else begin
      if (s_axi_awvalid & ~aw_full_ff) begin
        aw_full_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end else if (wr_en) begin
        aw_full_ff <= 1'b0;
      end
      if (s_axi_wvalid & ~w_full_ff) begin
        w_full_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end else if (wr_en) begin
        w_full_ff <= 1'b0;
      end
      if (wr_en) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? `RPC_RESP_OK : `RPC_RESP_ERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Reads answer one cycle after the address is taken.
  always @(posedge clk_sys) begin
    if (srst) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= `RPC_RESP_OK;
      rdata_ff  <= 32'h0000_0000;
    end else if (s_axi_arvalid & ~rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= rd_hit ? `RPC_RESP_OK : `RPC_RESP_ERR;
      rdata_ff  <= rd_hit ? rd_data : 32'h0000_0000;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule // rpc_axil

// *** rpc_code_chk.v ***
// Purpose: Judges whether a control code may be executed.
// Assumes: All inputs are steady in the cycle they are used.
// Notes:   Purely combinational.
`timescale 1ns/1ns
`include "rpc_map.vh"
module rpc_code_chk (
  // Code and enables
  input  wire [7:0] code,
  input  wire       en1,
  input  wire       en2,
  input  wire       both_used,
  // Verdict
  output reg        code_ok
);
  // With one enable in use either discrete counts as that enable.
  always @* begin
    case (code)
      `RPC_CC_NONE, `RPC_CC_EXEC, `RPC_CC_REVERT: code_ok = en1 | en2;
      `RPC_CC_EXIT2, `RPC_CC_ENTR2: code_ok = both_used ? en2 : (en1 | en2);
      `RPC_CC_EXIT1, `RPC_CC_ENTR1: code_ok = both_used ? en1 : (en1 | en2);
      `RPC_CC_EXITB, `RPC_CC_ENTRB: code_ok = both_used ? (en1 & en2) : (en1 | en2);
      default: code_ok = 1'b0;
    endcase
  end
endmodule // rpc_code_chk

// *** rpc_core.v ***
// Purpose: Remote terminal message logic for reprogram polling and control.
// Assumes: A bus front end delivers address-matched command and data words.
// Notes:   Word encoding and bus timing are handled outside this block.
`timescale 1ns/1ns
`include "rpc_map.vh"
module rpc_core (
  // Clock and reset
  input  wire               clk_sys,
  input  wire               srst,
  // AXI4-Lite register port
  input  wire [`RPC_AW-1:0] s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output wire               s_axi_awready,
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output wire               s_axi_wready,
  output wire [1:0]         s_axi_bresp,
  output wire               s_axi_bvalid,
  input  wire               s_axi_bready,
  input  wire [`RPC_AW-1:0] s_axi_araddr,
  input  wire               s_axi_arvalid,
  output wire               s_axi_arready,
  output wire [31:0]        s_axi_rdata,
  output wire [1:0]         s_axi_rresp,
  output wire               s_axi_rvalid,
  input  wire               s_axi_rready,
  // Terminal identity and enable discretes
  input  wire [4:0]         rt_addr,
  input  wire               reprog_en1,
  input  wire               reprog_en2,
  // Received words from the bus front end
  input  wire               cmd_vld,
  input  wire [15:0]        cmd_word,
  input  wire               rx_vld,
  input  wire [15:0]        rx_word,
  // Words to transmit, status first on transmit commands
  output wire               tx_vld,
  output wire [15:0]        tx_word,
  output wire               tx_last,
  input  wire               tx_rdy,
  // Reprogramming outcome
  output wire               area1_active,
  output wire               area2_active,
  output wire               load_follows,
  output wire               verify_follows,
  output wire               exec_entry,
  output wire               revert_to_bc
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RXD  = 4'b0010;
  localparam [3:0] ST_TXS  = 4'b0100;
  localparam [3:0] ST_TXD  = 4'b1000;

  // Byte-lane merge shared by every writable register.
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          wmerge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // Request field slices; f_sa serves commands and request bits, f_wc commands only.
  function [4:0] f_sa;
    input [15:0] w;
    f_sa = w[9:5];
  endfunction
  function [4:0] f_wc;
    input [15:0] w;
    f_wc = w[4:0];
  endfunction

  // Control: busy, busy-in-data mode, both enables used, second area present.
  reg [3:0]   ctrl_ff;
  reg [10:0]  req_ff;
  reg         req_pend_ff;
  reg [15:0]  cfg1_ff;
  reg [15:0]  cfg2_ff;
  reg [15:0]  nom0_ff;
  reg [15:0]  nom1_ff;
  reg [15:0]  nom2_ff;
  reg [5:0]   fill_ff;
  reg [4:0]   rssa_ff;
  // Block state seen by software and by the loader.
  reg         started_ff;
  reg         area1_ff;
  reg         area2_ff;
  reg         load_ff;
  reg         verify_ff;
  reg         reject_ff;
  reg [7:0]   last_code_ff;
  reg         exec_ff;
  reg         revert_ff;
  // Message sequencer.
  reg [3:0]   state_ff;
  reg [15:0]  cmd_ff;
  reg [5:0]   left_ff;
  reg [1:0]   widx_ff;
  reg         me_ff;
  reg         drop_ff;
  reg [15:0]  tx_word_ff;
  reg         tx_last_ff;
  reg         word_ok_ff;
  reg [7:0]   code_ff;
  reg [1:0]   lv_ff;

  wire               wr_en;
  wire [`RPC_AW-1:0] wr_addr;
  wire [31:0]        wr_data;
  wire [3:0]         wr_strb;
  reg                wr_hit;
  reg  [31:0]        rd_data;
  reg                rd_hit;
  wire               code_ok;

  wire busy_req   = ctrl_ff[0];
  wire busy_in_dw = ctrl_ff[1];
  wire both_used  = ctrl_ff[2];
  wire has_area2  = ctrl_ff[3];
  // Busy shows in the status word unless the terminal reports it in data.
  wire sts_busy   = busy_req & ~busy_in_dw;
  wire dw_busy    = busy_req & busy_in_dw;
  wire req_is_rs  = req_ff[`RPC_BIT_TR] & (f_sa({5'h00, req_ff}) == rssa_ff);
  // A status request waits for reprogramming and may ride with busy set.
  wire req_show   = req_pend_ff & (req_is_rs ? started_ff : ~dw_busy);
  wire [15:0] act_word = {dw_busy, 4'h0, req_show ? req_ff : 11'h000};
  wire [15:0] sts_word = {rt_addr, me_ff, 6'h00, sts_busy, 3'h0};

  wire        c_tr   = cmd_word[`RPC_BIT_TR];
  wire [4:0]  c_sa   = f_sa(cmd_word);
  wire [4:0]  c_wc   = f_wc(cmd_word);
  wire [5:0]  c_cnt  = (c_wc == 5'h00) ? 6'h20 : {1'b0, c_wc};
  wire        is_act = c_tr & (c_sa == `RPC_SA_ACT) & (c_wc == `RPC_WC_ACT);
  wire        is_cfg = c_tr & (c_sa == `RPC_SA_CFG) & (c_wc == `RPC_WC_CFG);
  wire        is_ctl = ~c_tr & (c_sa == `RPC_SA_CTL) & (c_wc == `RPC_WC_CTL);
  wire        legal  = is_act | is_cfg | is_ctl;
  // While busy only activity messages are served; others get status only.
  wire        refuse = busy_req & ~is_act;
  wire        tx_fire = tx_vld & tx_rdy;

  assign tx_vld         = state_ff[2] | state_ff[3];
  assign tx_word        = tx_word_ff;
  assign tx_last        = tx_last_ff;
  assign area1_active   = area1_ff;
  assign area2_active   = area2_ff;
  assign load_follows   = load_ff;
  assign verify_follows = verify_ff;
  assign exec_entry     = exec_ff;
  assign revert_to_bc   = revert_ff;

  rpc_axil u_axil (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_hit        (wr_hit),
    .rd_data       (rd_data),
    .rd_hit        (rd_hit)
  );

  rpc_code_chk u_chk (
    .code      (code_ff),
    .en1       (reprog_en1),
    .en2       (reprog_en2),
    .both_used (both_used),
    .code_ok   (code_ok)
  );

  // Write decode; the status register is read-only so writes to it fail.
  always @* begin
    case (wr_addr)
      `RPC_A_CTRL, `RPC_A_REQ, `RPC_A_CFG, `RPC_A_NOM0, `RPC_A_NOM1,
      `RPC_A_NOM2, `RPC_A_FILL, `RPC_A_RSSA: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Read decode from the live read address.
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `RPC_A_CTRL: rd_data = {28'h0000000, ctrl_ff};
      `RPC_A_REQ:  rd_data = {16'h0000, req_pend_ff, 4'h0, req_ff};
      `RPC_A_STAT: rd_data = {16'h0000, last_code_ff, 2'h0, reject_ff, verify_ff, load_ff,
                              area2_ff, area1_ff, started_ff};
      `RPC_A_CFG:  rd_data = {cfg2_ff, cfg1_ff};
      `RPC_A_NOM0: rd_data = {16'h0000, nom0_ff};
      `RPC_A_NOM1: rd_data = {16'h0000, nom1_ff};
      `RPC_A_NOM2: rd_data = {16'h0000, nom2_ff};
      `RPC_A_FILL: rd_data = {26'h0000000, fill_ff};
      `RPC_A_RSSA: rd_data = {27'h0000000, rssa_ff};
      default: begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // Old contents of the register being written; the strobed lanes merge into it.
  reg [31:0] wr_old;
  reg [31:0] wr_mrg;
  always @* begin
    case (wr_addr)
      `RPC_A_CTRL: wr_old = {28'h0000000, ctrl_ff};
      `RPC_A_REQ:  wr_old = {16'h0000, req_pend_ff, 4'h0, req_ff};
      `RPC_A_CFG:  wr_old = {cfg2_ff, cfg1_ff};
      `RPC_A_NOM0: wr_old = {16'h0000, nom0_ff};
      `RPC_A_NOM1: wr_old = {16'h0000, nom1_ff};
      `RPC_A_NOM2: wr_old = {16'h0000, nom2_ff};
      `RPC_A_FILL: wr_old = {26'h0000000, fill_ff};
      `RPC_A_RSSA: wr_old = {27'h0000000, rssa_ff};
      default:     wr_old = 32'h0000_0000;
    endcase
    wr_mrg = wmerge(wr_old, wr_data, wr_strb);
  end

  // Software registers. The pending request is cleared when the loader issues
  // the matching command; a software write in the same cycle wins.
  always @(posedge clk_sys) begin
    if (srst) begin
      ctrl_ff     <= `RPC_CTRL_RST;
      req_ff      <= 11'h000;
      req_pend_ff <= 1'b0;
      cfg1_ff     <= 16'h0000;
      cfg2_ff     <= 16'h0000;
      nom0_ff     <= 16'h0000;
      nom1_ff     <= 16'h0000;
      nom2_ff     <= 16'h0000;
      fill_ff     <= 6'h00;
      rssa_ff     <= `RPC_RSSA_RST;
    end else begin
      if (cmd_vld & req_pend_ff & req_show & (cmd_word[10:0] == req_ff))
        req_pend_ff <= 1'b0;
      if (wr_en) begin
        case (wr_addr)
          `RPC_A_CTRL: ctrl_ff <= wr_mrg[3:0];
          `RPC_A_REQ: begin
            req_ff      <= wr_mrg[10:0];
            req_pend_ff <= wr_mrg[15];
          end
          `RPC_A_CFG: {cfg2_ff, cfg1_ff} <= wr_mrg;
          `RPC_A_NOM0: nom0_ff <= wr_mrg[15:0];
          `RPC_A_NOM1: nom1_ff <= wr_mrg[15:0];
          `RPC_A_NOM2: nom2_ff <= wr_mrg[15:0];
          `RPC_A_FILL: fill_ff <= wr_mrg[5:0];
          `RPC_A_RSSA: rssa_ff <= wr_mrg[4:0];
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
    end
  end

  // Message sequencer: receive data, then status; or status, then data.
  always @(posedge clk_sys) begin
    if (srst) begin
      state_ff   <= ST_IDLE;
      cmd_ff     <= 16'h0000;
      left_ff    <= 6'h00;
      widx_ff    <= 2'h0;
      me_ff      <= 1'b0;
      drop_ff    <= 1'b0;
      tx_word_ff <= 16'h0000;
      tx_last_ff <= 1'b0;
      word_ok_ff <= 1'b0;
      code_ff    <= `RPC_CC_NONE;
      lv_ff      <= 2'b00;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (cmd_vld) begin
            cmd_ff     <= cmd_word;
            me_ff      <= ~legal;
            drop_ff    <= refuse | ~legal;
            widx_ff    <= 2'h0;
            word_ok_ff <= 1'b1;
            if (c_tr) begin
              state_ff   <= ST_TXS;
              tx_word_ff <= {rt_addr, ~legal, 6'h00, sts_busy, 3'h0};
              // Undefined transmit commands, and any but activity messages while busy, return status alone.
              tx_last_ff <= refuse | ~legal;
              left_ff    <= is_cfg ? {1'b0, `RPC_WC_CFG} : {1'b0, `RPC_WC_ACT};
            end else begin
              state_ff <= ST_RXD;
              left_ff  <= c_cnt;
            end
          end
        end
        ST_RXD: begin
          if (rx_vld) begin
            left_ff <= left_ff - 6'h01;
            widx_ff <= widx_ff + 2'h1;
            // Each control word is checked against its expected value.
            case (widx_ff)
              2'h0: word_ok_ff <= word_ok_ff & (rx_word == nom0_ff);
              2'h1: word_ok_ff <= word_ok_ff & (rx_word == nom1_ff);
              2'h2: word_ok_ff <= word_ok_ff & (rx_word == nom2_ff);
              default: begin
                word_ok_ff <= word_ok_ff & (rx_word[15:10] == fill_ff) &
                              (rx_word[9:8] != `RPC_LV_UNUSED);
                lv_ff      <= rx_word[9:8];
                code_ff    <= rx_word[7:0];
              end
            endcase
            if (left_ff == 6'h01) begin
              state_ff   <= ST_TXS;
              tx_word_ff <= sts_word;
              tx_last_ff <= 1'b1;
            end
          end
        end
        ST_TXS: begin
          if (tx_fire) begin
            me_ff <= 1'b0;
            if (tx_last_ff) begin
              state_ff <= ST_IDLE;
            end else begin
              state_ff   <= ST_TXD;
              left_ff    <= left_ff - 6'h01;
              tx_last_ff <= (left_ff == 6'h01);
              // The second area word reads zero on single-area units.
              tx_word_ff <= (cmd_ff[9:5] == `RPC_SA_CFG) ? cfg1_ff : act_word;
            end
          end
        end
        ST_TXD: begin
          if (tx_fire) begin
            if (tx_last_ff) begin
              state_ff <= ST_IDLE;
            end else begin
              left_ff    <= left_ff - 6'h01;
              tx_last_ff <= (left_ff == 6'h01);
              tx_word_ff <= has_area2 ? cfg2_ff : 16'h0000;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // A control message takes effect after its last word, once per message.
  wire ctl_done = state_ff[1] & rx_vld & (left_ff == 6'h01) & ~drop_ff &
                  (cmd_ff[9:5] == `RPC_SA_CTL);
  reg  ctl_eval_ff;

  // The code is judged one cycle later, after the last word is latched.
  always @(posedge clk_sys) begin
    if (srst) begin
      ctl_eval_ff  <= 1'b0;
      started_ff   <= 1'b0;
      area1_ff     <= 1'b0;
      area2_ff     <= 1'b0;
      load_ff      <= 1'b0;
      verify_ff    <= 1'b0;
      reject_ff    <= 1'b0;
      last_code_ff <= `RPC_CC_NONE;
      exec_ff      <= 1'b0;
      revert_ff    <= 1'b0;
    end else begin
      ctl_eval_ff <= ctl_done;
      exec_ff     <= 1'b0;
      revert_ff   <= 1'b0;
      if (ctl_eval_ff) begin
        last_code_ff <= code_ff;
        // Nothing executes unless every field checks and an enable is present.
        reject_ff    <= ~(word_ok_ff & code_ok);
        if (word_ok_ff & code_ok) begin
          started_ff <= 1'b1;
          load_ff    <= (lv_ff == `RPC_LV_LOAD);
          verify_ff  <= (lv_ff == `RPC_LV_VERIFY);
          case (code_ff)
            `RPC_CC_EXEC:   exec_ff   <= 1'b1;
            `RPC_CC_REVERT: revert_ff <= 1'b1;
            `RPC_CC_ENTR1:  area1_ff  <= 1'b1;
            `RPC_CC_ENTR2:  area2_ff  <= 1'b1;
            `RPC_CC_ENTRB: begin
              area1_ff <= 1'b1;
              area2_ff <= 1'b1;
            end
            `RPC_CC_EXIT1:  area1_ff  <= 1'b0;
            `RPC_CC_EXIT2:  area2_ff  <= 1'b0;
            `RPC_CC_EXITB: begin
              area1_ff <= 1'b0;
              area2_ff <= 1'b0;
            end
            default: started_ff <= 1'b1;
          endcase
        end
      end
    end
  end
endmodule // rpc_core

// *** rpc_core_assertions.sv ***
// Purpose: Port checks for rpc_core.
// Assumes: One clock, srst synchronous.
// Notes:   Bound to rpc_core below.
`timescale 1ns/1ns
module rpc_chk (
  // Clock and reset
  input wire        clk_sys, srst,
  // Message port
  input wire        cmd_vld, rx_vld, tx_vld, tx_last, tx_rdy,
  input wire [15:0] cmd_word, tx_word,
  input wire [4:0]  rt_addr,
  // Outcome
  input wire        reprog_en1, reprog_en2, area1_active,
  input wire        load_follows, verify_follows, exec_entry, revert_to_bc
);
  reg act_ff;
  // Marks a reply to a poll, so data-word checks skip other replies.
  always @(posedge clk_sys)
    if (srst) act_ff <= 1'b0;
    else if (cmd_vld && !tx_vld) act_ff <= cmd_word[10:0] == 11'h4e1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  tx_hold_a: assert property (tx_vld && !tx_rdy |=> tx_vld && $stable(tx_word))
    else $error("tx word dropped");
  poll_stat_a: assert property (cmd_vld && !tx_vld && cmd_word[10:0] == 11'h4e1
    |=> tx_vld && !tx_last && tx_word[15:11] == rt_addr) else $error("poll status wrong");
  act_zero_a: assert property (act_ff && tx_vld && tx_last |-> tx_word[14:11] == 4'h0)
    else $error("spare bits set");
  busy_req_a: assert property (act_ff && tx_vld && tx_last && tx_word[15] |-> tx_word[10:0] == 0 || tx_word[10])
    else $error("busy with request");
  lv_one_a: assert property (!(load_follows && verify_follows)) else $error("load and verify");
  code_time_a: assert property ($rose(area1_active) || exec_entry || revert_to_bc |-> $past(rx_vld, 2))
    else $error("action off time");
  en_need_a: assert property ($rose(area1_active) |-> reprog_en1 || reprog_en2)
    else $error("entered without enable");
  exec_once_a: assert property (exec_entry |=> !exec_entry && !revert_to_bc)
    else $error("exec pulse long");
endmodule // rpc_chk
bind rpc_core rpc_chk u_sva (.*);

// *** rpc_loader.sv ***
// Purpose: Bus controller model taking the words the terminal sends.
// Assumes: The bench drives commands and receive data.
// Notes:   Stalls at random, as a busy controller may.
`timescale 1ns/1ns
module rpc_loader (
  // Clock
  input wire        clk_sys,
  // Transmit handshake
  input wire        tx_vld, tx_last,
  input wire [15:0] tx_word,
  output reg        tx_rdy
);
  logic [15:0] q[$];
  initial tx_rdy = 1'b0;
  // A word moves only when both sides agree.
  always @(posedge clk_sys) begin
    if (tx_vld && tx_rdy) q.push_back(tx_word);
    tx_rdy <= ($urandom % 3) != 0;
  end
endmodule // rpc_loader

// *** rpc_map.vh ***
// Purpose: Constants for the reprogram poll and control message block.
// Assumes: Included by every design file of the block.
// Notes:   Addresses are AXI4-Lite byte addresses.
`ifndef RPC_MAP_VH
`define RPC_MAP_VH
`define RPC_AW        8
`define RPC_A_CTRL    8'h00
`define RPC_A_REQ     8'h04
`define RPC_A_STAT    8'h08
`define RPC_A_CFG     8'h0c
`define RPC_A_NOM0    8'h10
`define RPC_A_NOM1    8'h14
`define RPC_A_NOM2    8'h18
`define RPC_A_FILL    8'h1c
`define RPC_A_RSSA    8'h20
`define RPC_RESP_OK   2'b00
`define RPC_RESP_ERR  2'b10
`define RPC_CTRL_RST  4'h0
`define RPC_RSSA_RST  5'h1e
`define RPC_SA_ACT    5'h07
`define RPC_SA_CFG    5'h13
`define RPC_SA_CTL    5'h1d
`define RPC_WC_ACT    5'h01
`define RPC_WC_CFG    5'h02
`define RPC_WC_CTL    5'h04
`define RPC_BIT_TR    10
`define RPC_BIT_ME    10
`define RPC_BIT_SBSY  3
`define RPC_BIT_DBSY  15
`define RPC_LV_LOAD   2'b01
`define RPC_LV_VERIFY 2'b10
`define RPC_LV_UNUSED 2'b11
`define RPC_CC_NONE   8'h00
`define RPC_CC_EXEC   8'h01
`define RPC_CC_REVERT 8'h02
`define RPC_CC_EXIT2  8'h10
`define RPC_CC_EXIT1  8'h20
`define RPC_CC_EXITB  8'h30
`define RPC_CC_ENTR2  8'h40
`define RPC_CC_ENTR1  8'h80
`define RPC_CC_ENTRB  8'hc0
`endif
